// [verif/keypad_contact_model.sv]
// Far side: keypad link sending a frame every 10 cycles, fault contacts.
// Assumes the bench steers link health and contact states.
`timescale 1ns/1ns
module keypad_contact_model (
   input  wire logic       clk,
   input  wire logic       link_up,
   input  wire logic [7:0] closed,
   output logic            keypad_rx,
   output logic      [7:0] di_pin
);
   logic [3:0] gap_ff;
   initial begin
      keypad_rx = 1'b0;
      gap_ff = 4'h0;
   end
   // Frame as a toggle; silent line holds its level
   always @(posedge clk) begin
      gap_ff <= (gap_ff == 4'h9) ? 4'h0 : gap_ff + 4'h1;
      if (link_up && gap_ff == 4'h9)
         keypad_rx <= !keypad_rx;
   end
   // Closed contact drives the pin high
   assign di_pin = closed;
endmodule

// [verif/tb.sv]
// Bench: register tasks, keypad and contact model, trip scenarios.
// Assumes short keypad timeout and overload span for simulation.
`timescale 1ns/1ns
module tb;
   logic        clk, rst, reg_wr, reg_rd, keypad_jog, link_up, keypad_rx;
   logic        output_block, decel_stop, fault_trip;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [7:0]  closed, di_pin;
   logic [2:0]  relay_out;
   int          n_fail, check_count, i;

   drive_protection_trip_logic #(.KP_TIMEOUT(50), .OL_FULL(1000))
      drive_protection_trip_logic_i (.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .di_pin(di_pin),
      .keypad_rx(keypad_rx), .keypad_jog(keypad_jog),
      .output_block(output_block), .decel_stop(decel_stop),
      .fault_trip(fault_trip), .relay_out(relay_out));
   keypad_contact_model keypad_contact_model_i (.clk(clk),
      .link_up(link_up), .closed(closed), .keypad_rx(keypad_rx),
      .di_pin(di_pin));

   initial begin
      clk = 1'b0;
      forever #4 clk = !clk;
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp,
                     input string what);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(what, exp, reg_rdata);
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      keypad_jog = 1'b0;
      link_up = 1'b1;
      closed = 8'h00;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(4'h0, 32'h0, "contact reset");
      rd(4'h4, 32'h2, "ctrl reset");
      wr(4'hF, 32'hFFFFFFFF);
      rd(4'hF, 32'h0, "unmapped read");
      wr(4'h0, 32'h7FF);
      rd(4'h0, 32'hFF, "contact bits");
      wr(4'h0, 32'h0);
      wr(4'h3, 32'h1E1D06);
      for (int m = 0; m < 4; m++) begin
         wr(4'h4, m);
         link_up <= 1'b0;
         wait_cyc(80);
         chk("relay", m == 1 ? 32'h6 : 32'h0, relay_out);
         chk("block", m == 2, output_block);
         chk("decel", m == 3, decel_stop);
         link_up <= 1'b1;
         wait_cyc(20);
         chk("recover", 32'h0, {relay_out, output_block, decel_stop});
      end
      wr(4'h4, 32'h16);
      link_up <= 1'b0;
      keypad_jog <= 1'b1;
      wait_cyc(80);
      chk("block other source", 32'h0, output_block);
      wr(4'h4, 32'h6);
      wait_cyc(80);
      chk("block jog", 32'h1, output_block);
      link_up <= 1'b1;
      wr(4'h4, 32'h0);
      keypad_jog <= 1'b0;
      wr(4'h1, 32'h4);
      closed <= 8'h02;
      wait_cyc(8);
      chk("no trip other", 32'h0, fault_trip);
      closed <= 8'h01;
      wait_cyc(8);
      chk("trip open", 32'h3, {fault_trip, output_block});
      rd(4'h5, 32'h61, "status trip");
      closed <= 8'h00;
      wait_cyc(4);
      wr(4'h4, 32'h100);
      wait_cyc(3);
      chk("cleared", 32'h0, fault_trip);
      wr(4'h0, 32'h1);
      wait_cyc(8);
      chk("trip closed type", 32'h1, fault_trip);
      closed <= 8'h01;
      wait_cyc(4);
      wr(4'h4, 32'h100);
      wait_cyc(8);
      chk("closed type idle", 32'h0, fault_trip);
      wr(4'h7, 32'h64);
      wr(4'h6, 32'h96);
      for (i = 0; i < 2000 && relay_out[0] !== 1'b1; i++) wait_cyc(1);
      chk("warn time", 32'h1, i >= 595 && i <= 615);
      chk("warn before trip", 32'h0, fault_trip);
      for (i = 0; i < 2000 && fault_trip !== 1'b1; i++) wait_cyc(1);
      chk("trip time", 32'h1, i >= 390 && i <= 410);
      give_verdict();
   end
endmodule

// [verif/trip_props.sv]
// Checker: bus, trip latch and keypad loss relations at the top ports.
// Assumes it is bound onto the top module, one clock domain.
`timescale 1ns/1ns
module trip_props #(
   parameter longint KP_TIMEOUT = trip_pkg::KP_TIMEOUT_CYC
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        keypad_rx,
   input wire logic        output_block,
   input wire logic        decel_stop,
   input wire logic        fault_trip
);
   logic   kp_ff;
   longint quiet_ff;
   logic   clr;
   assign clr = reg_wr && reg_addr == 4'h4 && reg_wdata[8];
   always_ff @(posedge clk) begin
      kp_ff <= keypad_rx;
   end
   // Cycles since the last frame seen at the pin
   always_ff @(posedge clk) begin
      if (rst || keypad_rx != kp_ff)
         quiet_ff <= 0;
      else if (quiet_ff < 2 * KP_TIMEOUT)
         quiet_ff <= quiet_ff + 1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence rd_contact_s;
      reg_rd && reg_addr == 4'h0;
   endsequence
   sequence toggle_s;
      $changed(keypad_rx);
   endsequence
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero outside read");
   contact_width_a: assert property (
      rd_contact_s |=> reg_rdata[31:8] == 24'h0)
      else $error("contact select reads unused bits");
   out_reset_a: assert property (
      $past(rst) |-> !fault_trip && !output_block && !decel_stop)
      else $error("outputs active after reset");
   trip_latch_a: assert property (
      fault_trip && !clr && !$past(clr) && !$past(clr, 2) |=> fault_trip)
      else $error("trip dropped without clear");
   trip_blocks_a: assert property (fault_trip |-> output_block)
      else $error("trip without output block");
   coast_wait_a: assert property (
      $rose(output_block) && !fault_trip |-> quiet_ff >= KP_TIMEOUT)
      else $error("block before keypad timeout");
   decel_wait_a: assert property (
      $rose(decel_stop) |-> quiet_ff >= KP_TIMEOUT)
      else $error("decel before keypad timeout");
   decel_clear_a: assert property (
      toggle_s |-> ##[1:8] !decel_stop)
      else $error("decel kept after keypad frame");
endmodule

bind drive_protection_trip_logic trip_props #(.KP_TIMEOUT(KP_TIMEOUT))
   trip_props_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .keypad_rx(keypad_rx),
   .output_block(output_block), .decel_stop(decel_stop),
   .fault_trip(fault_trip));

// [verilog/drive_protection_trip_logic.sv]
// Top: external trip inputs, overload warning, keypad loss handling.
// Assumes asynchronous contacts and keypad strobe; register port on clk.
//
// Overview of operation
// - An input terminal with function 4 trips the drive when active.
// - The contact type register has one bit per terminal, bits 8-10 unused.
// - Current above rated accumulates toward an inverse-time trip.
// - The warning rises at 60 percent of the 150 percent, 60 s budget.
// - An output set to function 6 carries the overload warning.
// - Keypad loss counts only while commands come from the keypad or during keypad jog.
// - Mode 0 takes no action on keypad loss.
// - Mode 1 drives outputs set to code 29 or 30 on keypad loss.
// - Mode 2, the default, blocks the output stage on keypad loss.
// - Mode 3 raises decel_stop to decelerate to stop on keypad loss.
// - Keypad jog operation is covered when the multi key selects jog.
`timescale 1ns/1ns
module drive_protection_trip_logic #(
   parameter int     NUM_DI      = trip_pkg::NUM_DI,
   parameter int     NUM_DO      = trip_pkg::NUM_DO,
   parameter longint KP_TIMEOUT  = trip_pkg::KP_TIMEOUT_CYC,
   parameter longint OL_FULL     = trip_pkg::OL_FULL_CYC
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   input  wire logic [NUM_DI-1:0] di_pin,
   input  wire logic              keypad_rx,
   input  wire logic              keypad_jog,
   output logic                   output_block,
   output logic                   decel_stop,
   output logic                   fault_trip,
   output logic      [NUM_DO-1:0] relay_out
);
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   // Field positions in the control and function words
   localparam int          MODE_LSB   = 0;
   localparam int          SRC_LSB    = 2;
   localparam int          MULTI_BIT  = 4;
   localparam int          CLR_BIT    = 8;
   localparam int          FUNC_W     = 8;
   localparam int          FUNCS_WORD = 4;
   localparam int          VAL_W      = 16;
   trip_pkg::reg_req_t             req;
   logic [NUM_DI-1:0]              di_s1_ff;
   logic [NUM_DI-1:0]              di_s2_ff;
   logic [2:0]                     kp_s_ff;
   logic [trip_pkg::SEL_W-1:0]     contact_ff;
   logic [7:0]                     di_func_ff [NUM_DI];
   logic [7:0]                     do_func_ff [NUM_DO];
   logic [1:0]                     kp_mode_ff;
   logic [1:0]                     cmd_src_ff;
   logic                           multi_key_ff;
   logic                           trip_clr_ff;
   logic [15:0]                    current_ff;
   logic [15:0]                    rated_ff;
   logic [31:0]                    kp_cnt_ff;
   logic                           kp_lost_ff;
   logic                           ext_trip_ff;
   logic                           ol_trip_ff;
   trip_pkg::drv_state_t           state_ff;
   trip_pkg::drv_state_t           nxt_state;
   logic [NUM_DI-1:0]              di_active;
   logic                           ext_hit;
   logic                           ol_warn;
   logic                           ol_trip;
   logic                           kp_frame;
   logic                           kp_guard;
   logic                           kp_src_ok;
   logic                           kp_jog_ok;
   logic [31:0]                    status;

   // Decoding of a function code against a match
   function automatic logic code_is(input logic [7:0] code,
                                    input logic [7:0] want);
      code_is = (code == want);
   endfunction

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // Contact pin synchronisers
   always_ff @(posedge clk) begin
      if (rst) begin
         di_s1_ff <= '0;
         di_s2_ff <= '0;
      end else begin
         di_s1_ff <= di_pin;
         di_s2_ff <= di_s1_ff;
      end
   end

   // Keypad line synchroniser plus one stage for edges
   always_ff @(posedge clk) begin
      if (rst) begin
         kp_s_ff <= 3'h0;
      end else begin
         kp_s_ff <= {kp_s_ff[1:0], keypad_rx};
      end
   end

   // Contact type and terminal function per input
   genvar gi;
   generate
      for (gi = 0; gi < NUM_DI; gi++) begin : g_di
         assign di_active[gi] = contact_ff[gi] ? ~di_s2_ff[gi]
                                               : di_s2_ff[gi];
         // Stored but unused bits above the terminals ignored here
      end
   endgenerate

   always_comb begin
      ext_hit = 1'b0;
      for (int i = 0; i < NUM_DI; i++) begin
         if (di_active[i] && code_is(di_func_ff[i], trip_pkg::DI_EXT_TRIP))
            ext_hit = 1'b1;
      end
   end

   // Register writes
   always_ff @(posedge clk) begin
      if (rst) begin
         contact_ff   <= trip_pkg::CONTACT_RST;
         kp_mode_ff   <= trip_pkg::KP_MODE_RST;
         cmd_src_ff   <= trip_pkg::CMD_SRC_KEYPAD;
         multi_key_ff <= trip_pkg::MULTI_KEY_JOG;
         current_ff   <= 16'h0000;
         rated_ff     <= 16'h0000;
         for (int i = 0; i < NUM_DI; i++) di_func_ff[i] <= 8'h00;
         for (int i = 0; i < NUM_DO; i++) do_func_ff[i] <= 8'h00;
      end else if (req.wr) begin
         unique case (req.addr)
            trip_pkg::ADDR_CONTACT:
               contact_ff <= req.wdata[trip_pkg::SEL_W-1:0];
            trip_pkg::ADDR_DI_FUNC_LO: begin
               for (int i = 0; i < FUNCS_WORD && i < NUM_DI; i++)
                  di_func_ff[i] <= req.wdata[FUNC_W*i +: FUNC_W];
            end
            trip_pkg::ADDR_DI_FUNC_HI: begin
               for (int i = FUNCS_WORD; i < NUM_DI; i++)
                  di_func_ff[i] <= req.wdata[FUNC_W*(i-FUNCS_WORD) +: FUNC_W];
            end
            trip_pkg::ADDR_DO_FUNC: begin
               for (int i = 0; i < NUM_DO; i++)
                  do_func_ff[i] <= req.wdata[FUNC_W*i +: FUNC_W];
            end
            trip_pkg::ADDR_CTRL: begin
               kp_mode_ff   <= req.wdata[MODE_LSB +: 2];
               cmd_src_ff   <= req.wdata[SRC_LSB +: 2];
               multi_key_ff <= req.wdata[MULTI_BIT];
            end
            trip_pkg::ADDR_CURRENT: current_ff <= req.wdata[VAL_W-1:0];
            trip_pkg::ADDR_RATED:   rated_ff   <= req.wdata[VAL_W-1:0];
            default: ;
         endcase
      end
   end

   // Trip clear strobe: CTRL bit 8
   always_ff @(posedge clk) begin
      if (rst) begin
         trip_clr_ff <= 1'b0;
      end else begin
         trip_clr_ff <= req.wr && (req.addr == trip_pkg::ADDR_CTRL)
                        && req.wdata[CLR_BIT];
      end
   end

   overload_integrator #(.FULL_CYC(OL_FULL)) u_ol (
      .clk     (clk),
      .rst     (rst),
      .current (current_ff),
      .rated   (rated_ff),
      .warn    (ol_warn),
      .trip    (ol_trip)
   );

   // Keypad link supervision
   assign kp_frame = kp_s_ff[1] ^ kp_s_ff[2];
   assign kp_src_ok = cmd_src_ff == trip_pkg::CMD_SRC_KEYPAD;
   assign kp_jog_ok = keypad_jog
                      && multi_key_ff == trip_pkg::MULTI_KEY_JOG;
   assign kp_guard  = kp_src_ok || kp_jog_ok;
   always_ff @(posedge clk) begin
      if (rst || kp_frame || !kp_guard) begin
         kp_cnt_ff  <= ZERO32;
         kp_lost_ff <= 1'b0;
      end else if (longint'(kp_cnt_ff) >= KP_TIMEOUT - 1) begin
         kp_lost_ff <= 1'b1;
      end else begin
         kp_cnt_ff <= kp_cnt_ff + 32'h0000_0001;
      end
   end

   // Latched trips; a new event wins over the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_trip_ff <= 1'b0;
      end else begin
         ext_trip_ff <= ext_hit || (ext_trip_ff && !trip_clr_ff);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ol_trip_ff <= 1'b0;
      end else begin
         ol_trip_ff <= ol_trip || (ol_trip_ff && !trip_clr_ff);
      end
   end

   // Output stage state
   always_comb begin
      nxt_state = trip_pkg::ST_RUN;
      if (ext_trip_ff || ol_trip_ff) begin
         nxt_state = trip_pkg::ST_BLOCK;
      end else if (kp_lost_ff) begin
         unique case (trip_pkg::kp_mode_t'(kp_mode_ff))
            trip_pkg::KP_NONE:  nxt_state = trip_pkg::ST_RUN;
            trip_pkg::KP_WARN:  nxt_state = trip_pkg::ST_RUN;
            trip_pkg::KP_COAST: nxt_state = trip_pkg::ST_BLOCK;
            trip_pkg::KP_DEC:   nxt_state = trip_pkg::ST_DECEL;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= trip_pkg::ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         output_block <= 1'b0;
         decel_stop   <= 1'b0;
      end else begin
         output_block <= nxt_state == trip_pkg::ST_BLOCK;
         decel_stop   <= nxt_state == trip_pkg::ST_DECEL;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         fault_trip <= 1'b0;
      end else begin
         fault_trip <= ext_trip_ff || ol_trip_ff;
      end
   end

   // Relay outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         relay_out <= '0;
      end else begin
         for (int i = 0; i < NUM_DO; i++) begin
            relay_out[i] <=
               (code_is(do_func_ff[i], trip_pkg::DO_OL_WARN)
                && ol_warn)
               || ((code_is(do_func_ff[i], trip_pkg::DO_LOST_KP_A)
                    || code_is(do_func_ff[i], trip_pkg::DO_LOST_KP_B))
                   && kp_lost_ff
                   && kp_mode_ff == trip_pkg::KP_WARN);
         end
      end
   end

   // Status word
   assign status = {25'h0000000, state_ff, 1'b0, kp_lost_ff, ol_warn,
                    ol_trip_ff, ext_trip_ff};

   // Read port: data in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= ZERO32;
      end else if (req.rd) begin
         unique case (req.addr)
            trip_pkg::ADDR_CONTACT:
               reg_rdata <= {21'h000000, 3'h0, contact_ff[7:0]};
            trip_pkg::ADDR_DI_FUNC_LO:
               reg_rdata <= {di_func_ff[3], di_func_ff[2],
                             di_func_ff[1], di_func_ff[0]};
            trip_pkg::ADDR_DI_FUNC_HI:
               reg_rdata <= {di_func_ff[7], di_func_ff[6],
                             di_func_ff[5], di_func_ff[4]};
            trip_pkg::ADDR_DO_FUNC:
               reg_rdata <= {8'h00, do_func_ff[2], do_func_ff[1],
                             do_func_ff[0]};
            trip_pkg::ADDR_CTRL:
               reg_rdata <= {27'h0000000, multi_key_ff, cmd_src_ff,
                             kp_mode_ff};
            trip_pkg::ADDR_STATUS:  reg_rdata <= status;
            trip_pkg::ADDR_CURRENT: reg_rdata <= {16'h0000, current_ff};
            trip_pkg::ADDR_RATED:   reg_rdata <= {16'h0000, rated_ff};
            default:                reg_rdata <= ZERO32;
         endcase
      end else begin
         reg_rdata <= ZERO32;
      end
   end
endmodule

// [verilog/overload_integrator.sv]
// Inverse-time overload accumulator.
// Assumes current and rated current in the same units, same clock domain.
`timescale 1ns/1ns
module overload_integrator #(
   parameter longint FULL_CYC = trip_pkg::OL_FULL_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] current,
   input  wire logic [15:0] rated,
   output logic             warn,
   output logic             trip
);
   localparam int ACC_W = 64;
   // Full scale: excess of 50 % rated for FULL_CYC cycles
   logic [ACC_W-1:0] acc_ff;
   logic [ACC_W-1:0] full;
   logic [ACC_W-1:0] warn_lvl;
   logic [16:0]      excess;
   logic             over;

   assign over   = current > rated;
   assign excess = over ? ({1'b0, current} - {1'b0, rated}) : 17'h00000;
   // Excess at 150 % is rated/2; full = rated/2 * FULL_CYC
   assign full = ACC_W'(FULL_CYC) * ACC_W'(rated)
                 * ACC_W'(trip_pkg::OL_PCT_FULL - trip_pkg::PCT_100)
                 / ACC_W'(trip_pkg::PCT_100);
   assign warn_lvl = full / ACC_W'(trip_pkg::PCT_100)
                     * ACC_W'(trip_pkg::OL_WARN_PCT);

   always_ff @(posedge clk) begin
      if (rst) begin
         acc_ff <= '0;
      end else if (over) begin
         acc_ff <= acc_ff + ACC_W'(excess);
      end else if (acc_ff != '0) begin
         acc_ff <= acc_ff - ACC_W'(1'b1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         warn <= 1'b0;
         trip <= 1'b0;
      end else begin
         warn <= (rated != 16'h0000) && (acc_ff >= warn_lvl);
         trip <= (rated != 16'h0000) && (acc_ff >= full);
      end
   end
endmodule

// [verilog/trip_pkg.sv]
// Package: register map, field codes, modes and timing for the trip logic.
// Assumes a 125 MHz clock and a plain address/strobe register port.
package trip_pkg;
   localparam int          CLK_HZ          = 125_000_000;
   localparam int          NUM_DI          = 8;
   localparam int          NUM_DO          = 3;
   localparam int          SEL_W           = 11;
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 32;
   // Register addresses
   localparam logic [3:0]  ADDR_CONTACT    = 4'h0;
   localparam logic [3:0]  ADDR_DI_FUNC_LO = 4'h1;
   localparam logic [3:0]  ADDR_DI_FUNC_HI = 4'h2;
   localparam logic [3:0]  ADDR_DO_FUNC    = 4'h3;
   localparam logic [3:0]  ADDR_CTRL       = 4'h4;
   localparam logic [3:0]  ADDR_STATUS     = 4'h5;
   localparam logic [3:0]  ADDR_CURRENT    = 4'h6;
   localparam logic [3:0]  ADDR_RATED      = 4'h7;
   localparam logic [3:0]  ADDR_KP_RX      = 4'h8;
   // Function codes
   localparam logic [7:0]  DI_EXT_TRIP     = 8'h04;
   localparam logic [7:0]  DO_OL_WARN      = 8'h06;
   localparam logic [7:0]  DO_LOST_KP_A    = 8'h1D;
   localparam logic [7:0]  DO_LOST_KP_B    = 8'h1E;
   localparam logic [1:0]  CMD_SRC_KEYPAD  = 2'h0;
   localparam logic        MULTI_KEY_JOG   = 1'b0;
   // Reset values
   localparam logic [10:0] CONTACT_RST     = 11'h000;
   localparam logic [1:0]  KP_MODE_RST     = 2'h2;
   // Overload model: 150 % for 60 s is full; warn at 60 %
   localparam int          OL_FULL_S       = 60;
   localparam int          OL_PCT_FULL     = 150;
   localparam int          OL_WARN_PCT     = 60;
   localparam int          PCT_100         = 100;
   localparam int          KP_TIMEOUT_MS   = 500;
   localparam longint      KP_TIMEOUT_CYC  =
      longint'(CLK_HZ) / 1000 * KP_TIMEOUT_MS;
   localparam longint      OL_FULL_CYC     = longint'(CLK_HZ) * OL_FULL_S;
   typedef enum logic [1:0] {
      KP_NONE = 2'h0, KP_WARN = 2'h1, KP_COAST = 2'h2, KP_DEC = 2'h3
   } kp_mode_t;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00, ST_DECEL = 2'b01, ST_BLOCK = 2'b11
   } drv_state_t;
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;
endpackage
